// ---- lcd_drv_pkg.sv ----
// Constants and types shared by the serial segment driver and its FIFO.
// Assumes a 100 MHz system clock; all times are converted to cycles here.
package lcd_drv_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int SEG_COUNT = 32;
  localparam int FIFO_DEPTH = 8;
  localparam logic [SEG_COUNT-1:0] SEG_RESET = 32'h00000000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Internal oscillator half period when the pin is left free
  localparam int OSC_HALF_PERIOD_NS = 31250;
  localparam int OSC_HALF_CYC_RAW = OSC_HALF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_HALF_CYC = (OSC_HALF_CYC_RAW < 1) ? 1 : OSC_HALF_CYC_RAW;
  // Waveform divider: 2^8 oscillator periods per drive period
  localparam int BP_DIV_BITS = 8;
  // Pin disagreement that marks an outside driver
  localparam int CONTEND_NS = 80;
  localparam int CONTEND_CYC_RAW = (CONTEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONTEND_CYC = (CONTEND_CYC_RAW < 1) ? 1 : CONTEND_CYC_RAW;
  // Silence on a driven pin before falling back to oscillating
  localparam int IDLE_TIMEOUT_NS = 100000000;
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic {
    AC_OSCILLATE = 1'b0,
    AC_DRIVEN = 1'b1
  } ac_mode_t;

endpackage : lcd_drv_pkg

// ---- seg_fifo_if.sv ----
// Carrier for the data path between the link logic and the segment FIFO.
// Clocks and resets travel as separate ports of the FIFO.
`timescale 1ns/1ps
`default_nettype none

interface seg_fifo_if #(
  parameter int WIDTH = lcd_drv_pkg::SEG_COUNT
);
  logic [WIDTH-1:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] rd_data;
  logic rd_valid;
  logic rd_ready;

  modport fifo_side (
    input wr_data, wr_valid, rd_ready,
    output wr_ready, rd_data, rd_valid
  );
  modport user_side (
    output wr_data, wr_valid, rd_ready,
    input wr_ready, rd_data, rd_valid
  );
endinterface : seg_fifo_if

`default_nettype wire

// ---- seg_async_fifo.sv ----
// Dual-clock FIFO with gray-coded pointers.
// Assumes each reset is synchronous to its own clock.
`timescale 1ns/1ps
`default_nettype none

module seg_async_fifo #(
  parameter int WIDTH = lcd_drv_pkg::SEG_COUNT,
  parameter int DEPTH = lcd_drv_pkg::FIFO_DEPTH
) (
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic rd_clk,
  input wire logic rd_rst,
  seg_fifo_if.fifo_side f
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("seg_async_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] q1;
    logic [AW:0] q2;
  } side_t;

  logic [WIDTH-1:0] mem [DEPTH];
  side_t w;
  side_t next_w;
  side_t r;
  side_t next_r;
  logic [AW:0] w_bin_inc;
  logic [AW:0] r_bin_inc;

  // ----------------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------------
  assign f.wr_ready = (w.gray != {~w.q2[AW:AW-1], w.q2[AW-2:0]});
  assign w_bin_inc = w.bin + 1'b1;

  always_comb begin
    next_w = w;
    next_w.q1 = r.gray;
    next_w.q2 = w.q1;
    if (f.wr_valid && f.wr_ready) begin
      next_w.bin = w_bin_inc;
      next_w.gray = w_bin_inc ^ (w_bin_inc >> 1);
    end
  end

  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      w <= '0;
    end else begin
      w <= next_w;
      if (f.wr_valid && f.wr_ready) begin
        mem[w.bin[AW-1:0]] <= f.wr_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------------
  assign f.rd_valid = (r.gray != r.q2);
  assign f.rd_data = mem[r.bin[AW-1:0]];
  assign r_bin_inc = r.bin + 1'b1;

  always_comb begin
    next_r = r;
    next_r.q1 = w.gray;
    next_r.q2 = r.q1;
    if (f.rd_valid && f.rd_ready) begin
      next_r.bin = r_bin_inc;
      next_r.gray = r_bin_inc ^ (r_bin_inc >> 1);
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : seg_async_fifo

`default_nettype wire

// ---- serial_segment_lcd_driver.sv ----
// Serial-input static segment driver: shift chain, load latches, AC drive.
// Assumes the shift clock comes from the controller and may stop between
// transfers; load and the AC pin are asynchronous to sys_clk.
//
// Notes on behaviour
// - Sample serial in, shift, and update serial out on shift clock falling edge.
// - Shifted-in one means segment on; zero means segment off.
// - While load is high, shift register copies into the segment latches.
// - Externally driven AC pin gives an in-phase backplane output.
// - Sense driven versus oscillating AC pin; driven mode passes pin to backplane.
// - Oscillating mode divides oscillator by two to the eighth for waveforms.
// - Serial out may chain into next device, or devices load in parallel.
// - Segment N holds the bit presented N clock pulses earlier.
// - Load tied high makes latches transparent; two lines then suffice.
// - Thirty-two segment outputs, each with one shift stage and latch.
`timescale 1ns/1ps
`default_nettype none

module serial_segment_lcd_driver #(
  parameter int SEG_COUNT = lcd_drv_pkg::SEG_COUNT,
  parameter int FIFO_DEPTH = lcd_drv_pkg::FIFO_DEPTH,
  parameter int OSC_HALF_CYC = lcd_drv_pkg::OSC_HALF_CYC,
  parameter int IDLE_TIMEOUT_CYC = lcd_drv_pkg::IDLE_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic load,
  output logic serial_out,
  input wire logic ac_frequency_pin_in,
  output logic ac_frequency_pin_out,
  output logic ac_frequency_pin_oe_n,
  output logic backplane,
  output logic [SEG_COUNT-1:0] segment,
  output logic ac_driven,
  output logic link_push_stall
);
  localparam int OSC_W = $clog2(OSC_HALF_CYC + 1);
  localparam int IDLE_W = $clog2(IDLE_TIMEOUT_CYC + 1);
  localparam int CON_W = $clog2(lcd_drv_pkg::CONTEND_CYC + 1);
  localparam int DIV_W = lcd_drv_pkg::BP_DIV_BITS;

  if (SEG_COUNT < 2) begin : g_bad_seg
    $error("serial_segment_lcd_driver: SEG_COUNT must be at least 2");
  end
  if (OSC_HALF_CYC < 1 || IDLE_TIMEOUT_CYC < 2) begin : g_bad_time
    $error("serial_segment_lcd_driver: timing counts out of range");
  end

  // ----------------------------------------------------------------------
  // Link domain, falling edge of the shift clock
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rst_l1;
    logic rst_l2;
    logic [SEG_COUNT-1:0] chain;
    logic [1:0] fall_gray;
    logic sout;
  } link_t;

  link_t lk;
  link_t next_lk;

  seg_fifo_if #(.WIDTH(SEG_COUNT)) fq ();

  always_comb begin
    next_lk = lk;
    next_lk.rst_l1 = rst;
    next_lk.rst_l2 = lk.rst_l1;
    if (lk.rst_l2) begin
      next_lk.chain = lcd_drv_pkg::SEG_RESET;
      next_lk.fall_gray = 2'h0;
      next_lk.sout = 1'b0;
    end else begin
      // Newest bit enters stage 0, which is segment 1
      next_lk.chain = {lk.chain[SEG_COUNT-2:0], serial_in};
      // Gray count of falling edges, read by the system side
      next_lk.fall_gray = {lk.fall_gray[0], ~lk.fall_gray[1]};
      next_lk.sout = lk.chain[SEG_COUNT-2];
    end
  end

  always_ff @(negedge shift_clk) begin
    lk <= next_lk;
  end

  assign serial_out = lk.sout;

  // Chain image is taken on sys_clk once the edge count has settled,
  // so a frame whose clock stops right after its last bit still lands
  seg_async_fifo #(
    .WIDTH(SEG_COUNT),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(sys_clk),
    .wr_rst(rst),
    .rd_clk(sys_clk),
    .rd_rst(rst),
    .f(fq.fifo_side)
  );

  // ----------------------------------------------------------------------
  // System domain state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SEG_COUNT-1:0] shadow;
    logic [SEG_COUNT-1:0] latch;
    logic [SEG_COUNT-1:0] seg;
    logic load_s1;
    logic load_s2;
    logic stall_s1;
    logic stall_s2;
    logic ac_s1;
    logic ac_s2;
    logic ac_s3;
    logic osc;
    logic osc_d1;
    logic osc_d2;
    logic [OSC_W-1:0] osc_cnt;
    logic [DIV_W-1:0] div;
    lcd_drv_pkg::ac_mode_t mode;
    logic [CON_W-1:0] contend;
    logic [IDLE_W-1:0] idle;
    logic bp;
    logic [1:0] cnt_s1;
    logic [1:0] cnt_s2;
    logic [1:0] cnt_s3;
    logic [1:0] cnt_s4;
    logic [SEG_COUNT-1:0] cap1;
    logic [SEG_COUNT-1:0] cap2;
    logic [SEG_COUNT-1:0] cap3;
    logic moved;
  } sys_t;

  sys_t s;
  sys_t next_s;

  logic push_want;

  // Count unchanged over three samples: the image three cycles back was still
  assign push_want = s.moved && (s.cnt_s2 == s.cnt_s3) && (s.cnt_s3 == s.cnt_s4);
  assign fq.wr_valid = push_want;
  assign fq.wr_data = s.cap3;
  assign fq.rd_ready = 1'b1;

  always_comb begin
    next_s = s;
    // Synchronisers: first stage feeds only the second
    next_s.load_s1 = load;
    next_s.load_s2 = s.load_s1;
    next_s.stall_s1 = push_want & ~fq.wr_ready;
    next_s.stall_s2 = s.stall_s1;
    next_s.cnt_s1 = lk.fall_gray;
    next_s.cnt_s2 = s.cnt_s1;
    next_s.cnt_s3 = s.cnt_s2;
    next_s.cnt_s4 = s.cnt_s3;
    next_s.cap1 = lk.chain;
    next_s.cap2 = s.cap1;
    next_s.cap3 = s.cap2;
    if (s.cnt_s3 != s.cnt_s4) begin
      next_s.moved = 1'b1;
    end else if (push_want && fq.wr_ready) begin
      next_s.moved = 1'b0;
    end
    next_s.ac_s1 = ac_frequency_pin_in;
    next_s.ac_s2 = s.ac_s1;
    next_s.ac_s3 = s.ac_s2;

    // Latest chain image from the link
    if (fq.rd_valid) begin
      next_s.shadow = fq.rd_data;
    end
    // Transparent while load stays high
    if (s.load_s2) begin
      next_s.latch = s.shadow;
    end

    // Internal oscillator
    if (s.osc_cnt == OSC_W'(OSC_HALF_CYC - 1)) begin
      next_s.osc_cnt = '0;
      next_s.osc = ~s.osc;
      if (!s.osc) begin
        next_s.div = s.div + 1'b1;
      end
    end else begin
      next_s.osc_cnt = s.osc_cnt + 1'b1;
    end
    // Own drive delayed to line up with the synchronised pin
    next_s.osc_d1 = s.osc;
    next_s.osc_d2 = s.osc_d1;

    case (s.mode)
      lcd_drv_pkg::AC_OSCILLATE: begin
        // Pin disagreeing with our own drive means someone else drives it
        if (s.ac_s2 != s.osc_d2) begin
          if (s.contend == CON_W'(lcd_drv_pkg::CONTEND_CYC - 1)) begin
            next_s.mode = lcd_drv_pkg::AC_DRIVEN;
            next_s.contend = '0;
            next_s.idle = '0;
          end else begin
            next_s.contend = s.contend + 1'b1;
          end
        end else begin
          next_s.contend = '0;
        end
        next_s.bp = s.div[DIV_W-1];
      end
      lcd_drv_pkg::AC_DRIVEN: begin
        if (s.ac_s2 != s.ac_s3) begin
          next_s.idle = '0;
        end else if (s.idle == IDLE_W'(IDLE_TIMEOUT_CYC - 1)) begin
          next_s.mode = lcd_drv_pkg::AC_OSCILLATE;
          next_s.idle = '0;
        end else begin
          next_s.idle = s.idle + 1'b1;
        end
        next_s.bp = s.ac_s2;
      end
      default: begin
        next_s.mode = lcd_drv_pkg::AC_OSCILLATE;
      end
    endcase

    // Off segments follow the backplane, on segments oppose it
    next_s.seg = next_s.latch ^ {SEG_COUNT{next_s.bp}};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.mode <= lcd_drv_pkg::AC_OSCILLATE;
      s.shadow <= lcd_drv_pkg::SEG_RESET;
      s.latch <= lcd_drv_pkg::SEG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign backplane = s.bp;
  assign segment = s.seg;
  assign ac_driven = (s.mode == lcd_drv_pkg::AC_DRIVEN);
  assign ac_frequency_pin_out = s.osc;
  assign ac_frequency_pin_oe_n = (s.mode == lcd_drv_pkg::AC_DRIVEN);
  assign link_push_stall = s.stall_s2;
endmodule : serial_segment_lcd_driver

`default_nettype wire

// ---- seg_ctl_model.sv ----
// Controller model: shifts words into the driver over the link.
// Link clock idles high and runs at a 6 ns period only inside a frame.
`timescale 1ns/1ps
`default_nettype none

module seg_ctl_model (
  output logic shift_clk,
  output logic serial_in
);
  initial begin
    shift_clk = 1'b1;
    serial_in = 1'b0;
  end

  // Highest bit first; data moves only while the clock is high
  task automatic send(input logic [31:0] word, input int nbits);
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = word[i];
      #3;
      shift_clk = 1'b0;
      #3;
      shift_clk = 1'b1;
    end
    serial_in = ~serial_in;
  endtask : send
endmodule : seg_ctl_model

`default_nettype wire

// ---- seg_drv_assertions.sv ----
// Checker on the ports of the segment driver top.
// Bound from the testbench; OSC_HALF_CYC follows the bound instance.
`timescale 1ns/1ps
`default_nettype none

module seg_drv_checker #(
  parameter int SEG_COUNT = 32,
  parameter int OSC_HALF_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic load,
  input wire logic serial_out,
  input wire logic ac_frequency_pin_in,
  input wire logic ac_frequency_pin_out,
  input wire logic ac_frequency_pin_oe_n,
  input wire logic backplane,
  input wire logic [SEG_COUNT-1:0] segment,
  input wire logic ac_driven,
  input wire logic link_push_stall
);
  localparam int BP_HALF = 256 * OSC_HALF_CYC;
  logic [23:0] bp_cnt;
  logic [1:0] bp_seen;
  logic bp_last;
  logic [5:0] fall_cnt;

  // Cycles since the last backplane edge in oscillating mode
  always_ff @(posedge sys_clk) begin
    bp_last <= backplane;
    bp_cnt <= (backplane != bp_last) ? 24'h000000 : bp_cnt + 24'h000001;
    if (rst || ac_driven) begin
      bp_seen <= 2'h0;
    end else if (backplane != bp_last && bp_seen != 2'h3) begin
      bp_seen <= bp_seen + 2'h1;
    end
  end

  always_ff @(negedge shift_clk or posedge rst) begin
    if (rst) begin
      fall_cnt <= 6'h00;
    end else if (fall_cnt != 6'h28) begin
      fall_cnt <= fall_cnt + 6'h01;
    end
  end

  sequence s_quiet;
    (!load) [*4];
  endsequence
  sequence s_drv;
    ac_driven [*4];
  endsequence

  property p_serial;
    @(negedge shift_clk) disable iff (rst)
    fall_cnt == 6'h28 |-> serial_out == $past(serial_in, 32);
  endproperty
  a_serial: assert property (p_serial) else $error("serial out lag wrong");

  property p_seg_flip;
    @(posedge sys_clk) disable iff (rst)
    s_quiet ##0 $changed(backplane) |-> segment == ~$past(segment);
  endproperty
  a_seg_flip: assert property (p_seg_flip) else $error("segments miss bp flip");

  property p_load_hold;
    @(posedge sys_clk) disable iff (rst)
    $changed(segment) && $stable(backplane) |-> $past(load, 3);
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("segments moved without load");

  property p_bp_follow;
    @(posedge sys_clk) disable iff (rst) s_drv |-> backplane == $past(ac_frequency_pin_in, 3);
  endproperty
  a_bp_follow: assert property (p_bp_follow) else $error("bp not following pin");

  property p_oe_mode;
    @(posedge sys_clk) disable iff (rst) ac_frequency_pin_oe_n == ac_driven;
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("pin enable disagrees with mode");

  property p_bp_div;
    @(posedge sys_clk) disable iff (rst)
    $changed(backplane) && bp_seen == 2'h3 && !ac_driven |-> bp_cnt == 24'(BP_HALF - 1);
  endproperty
  a_bp_div: assert property (p_bp_div) else $error("bp half period wrong");

  property p_osc_half;
    @(posedge sys_clk) disable iff (rst) !ac_driven && $rose(ac_frequency_pin_out)
      |-> ##OSC_HALF_CYC ($fell(ac_frequency_pin_out) || ac_driven);
  endproperty
  a_osc_half: assert property (p_osc_half) else $error("oscillator half period wrong");

  property p_rst_vals;
    @(posedge sys_clk) disable iff (rst) $fell(rst) |-> segment == '0 && !backplane && !ac_driven
      && !link_push_stall && !ac_frequency_pin_oe_n;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
endmodule : seg_drv_checker

`default_nettype wire

// ---- serial_segment_lcd_driver_test.sv ----
// Self-checking bench for the serial segment driver.
// Uses the controller model on the link and resolves the AC pin here.
`timescale 1ns/1ps
`default_nettype none

module serial_segment_lcd_driver_test;
  localparam int OSC_HALF = 4;
  localparam int BP_HALF = 256 * OSC_HALF;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic load = 1'b0;
  logic ext_en = 1'b0;
  logic ext_sq = 1'b0;
  logic [4:0] sq_cnt = 5'h00;
  logic shift_clk, serial_in, serial_out, pin_out, pin_oe_n, backplane, ac_driven, stall;
  logic [31:0] segment;
  int miscompares = 0;
  int check_count = 0;
  // Outside driver opposes the oscillator until sensed, then runs a square wave
  wire logic pin = ext_en ? (ext_sq ? sq_cnt[4] : ~pin_out) : (pin_oe_n ? 1'b0 : pin_out);

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) sq_cnt <= sq_cnt + 5'h01;

  seg_ctl_model i_ctl (.shift_clk(shift_clk), .serial_in(serial_in));

  serial_segment_lcd_driver #(.OSC_HALF_CYC(OSC_HALF), .IDLE_TIMEOUT_CYC(200)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .shift_clk(shift_clk), .serial_in(serial_in),
    .load(load), .serial_out(serial_out), .ac_frequency_pin_in(pin),
    .ac_frequency_pin_out(pin_out), .ac_frequency_pin_oe_n(pin_oe_n),
    .backplane(backplane), .segment(segment), .ac_driven(ac_driven),
    .link_push_stall(stall));

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cycles

  task automatic pulse_load();
    load <= 1'b1;
    cycles(3);
    load <= 1'b0;
    cycles(6);
  endtask : pulse_load

  task automatic wait_bp(output int n);
    logic b;
    b = backplane;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (backplane === b && n < 3000);
  endtask : wait_bp

  task automatic t_osc();
    int n;
    wait_bp(n);
    wait_bp(n);
    check(n == BP_HALF, "bp half period");
    check(ac_driven === 1'b0 && pin_oe_n === 1'b0, "oscillating mode");
    $display("t_osc done");
  endtask : t_osc

  task automatic t_load();
    logic [31:0] w1;
    logic [31:0] w2;
    w1 = 32'hA5C30F81;
    w2 = 32'h3C96E12F;
    i_ctl.send(w1, 32);
    cycles(8);
    check(serial_out === w1[31], "serial out first word");
    pulse_load();
    check(segment === (backplane ? ~w1 : w1), "segments first word");
    i_ctl.send(w2, 32);
    cycles(8);
    check(segment === (backplane ? ~w1 : w1), "segments held");
    check(serial_out === w2[31], "serial out second word");
    pulse_load();
    check(segment === (backplane ? ~w2 : w2), "segments second word");
    $display("t_load done");
  endtask : t_load

  task automatic t_transp();
    load <= 1'b1;
    i_ctl.send(32'hFFFF0001, 32);
    cycles(10);
    check(segment === (backplane ? 32'h0000FFFE : 32'hFFFF0001), "transparent");
    load <= 1'b0;
    cycles(4);
    $display("t_transp done");
  endtask : t_transp

  task automatic t_drv();
    int n;
    n = 0;
    ext_en <= 1'b1;
    do begin
      cycles(1);
      n++;
    end while (ac_driven !== 1'b1 && n < 100);
    check(n < 100 && pin_oe_n === 1'b1, "driven sensed");
    ext_sq <= 1'b1;
    repeat (96) begin
      @(posedge sys_clk);
      if (sq_cnt[3:0] == 4'h8) check(backplane === sq_cnt[4], "bp in phase");
    end
    ext_en <= 1'b0;
    ext_sq <= 1'b0;
    n = 0;
    do begin
      cycles(1);
      n++;
    end while (ac_driven !== 1'b0 && n < 400);
    check(n < 400, "back to oscillating");
    $display("t_drv done");
  endtask : t_drv

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    i_ctl.send(32'h00000000, 4);
    cycles(20);
    rst <= 1'b0;
    i_ctl.send(32'h00000000, 4);
    t_osc();
    t_load();
    t_transp();
    t_drv();
    wrap_up();
  end

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule : serial_segment_lcd_driver_test

bind serial_segment_lcd_driver seg_drv_checker #(.SEG_COUNT(SEG_COUNT),
  .OSC_HALF_CYC(OSC_HALF_CYC)) i_chk (.*);

`default_nettype wire
